// ---- hw/asrc_pkg.sv ----
package asrc_pkg;

  // ==========================================================
  // Geometry of the attached RAM
  // ==========================================================
  localparam int ADDR_W = 16;   // Word address width
  localparam int DATA_W = 4;    // Data width, separate in and out paths

  // ==========================================================
  // Clock and pin timing
  // ==========================================================
  localparam int CLK_PERIOD_NS = 8;   // 125 MHz host clock
  localparam int T_RC_NS       = 15;  // Least read cycle time
  localparam int T_AA_NS       = 15;  // Longest address to data valid
  localparam int T_PWE_NS      = 9;   // Least write strobe pulse
  localparam int T_SD_NS       = 9;   // Least data setup to write end
  localparam int T_SCE_NS      = 10;  // Least select low to write end

  // Times round up to whole cycles, the read count one cycle more; never below one
  localparam int RD_CYC =
    ((T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) + 1;
  localparam int WR_CYC_RAW =
    (T_SCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_CYC = (WR_CYC_RAW < 1) ? 1 : WR_CYC_RAW;
  localparam int CNT_W  = 4;   // Wide enough for both counts

  // Value of the pins after reset
  localparam logic       RST_SEL_B = 1'b1;
  localparam logic       RST_WR_B  = 1'b1;

  // ==========================================================
  // Sequencer states
  // ==========================================================
  typedef enum logic [2:0] {
    ASRC_IDLE  = 3'b000,
    ASRC_RSET  = 3'b001,
    ASRC_RWAIT = 3'b010,
    ASRC_WSET  = 3'b011,
    ASRC_WPUL  = 3'b100,
    ASRC_WEND  = 3'b101
  } asrc_state_t;

endpackage

// ---- hw/asrc_host.sv ----
`timescale 1ns/100ps

// Contract
// - Write starts only with both lines low
// - Host holds data around terminating rising edge
// - Host keeps strobe high during reads
// - Address-controlled read keeps select low
// - Address valid before select falls
module asrc_host #(
  parameter int ADDR_W = asrc_pkg::ADDR_W,
  parameter int DATA_W = asrc_pkg::DATA_W
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst_b,
  // User request side
  input  wire logic              i_req,
  input  wire logic              i_req_wr,
  input  wire logic [ADDR_W-1:0] i_req_addr,
  input  wire logic [DATA_W-1:0] i_req_wdata,
  output logic                   o_busy,
  output logic                   o_rd_valid,
  output logic [DATA_W-1:0]      o_rd_data,
  output logic                   o_wr_done,
  // RAM pins
  output logic                   o_sel_b,
  output logic                   o_wr_b,
  output logic [ADDR_W-1:0]      o_word_address,
  output logic [DATA_W-1:0]      o_write_data_in,
  input  wire logic [DATA_W-1:0] i_ram_dout
);

  // ==========================================================
  // State and registers
  // ==========================================================
  // Each register has a next value from the one combinational block
  asrc_pkg::asrc_state_t     state_r;     // Sequencer state
  asrc_pkg::asrc_state_t     state_nxt;
  logic [asrc_pkg::CNT_W-1:0] cnt_r;      // Cycle counter
  logic [asrc_pkg::CNT_W-1:0] cnt_nxt;
  logic                      sel_b_r;     // Select pin
  logic                      sel_b_nxt;
  logic                      wr_b_r;      // Write strobe pin
  logic                      wr_b_nxt;
  logic [ADDR_W-1:0]         addr_r;      // Address pin
  logic [ADDR_W-1:0]         addr_nxt;
  logic [DATA_W-1:0]         wdat_r;      // Write data pin
  logic [DATA_W-1:0]         wdat_nxt;
  logic [DATA_W-1:0]         rdat_r;      // Captured read data
  logic [DATA_W-1:0]         rdat_nxt;
  logic                      rvld_r;      // Read done pulse
  logic                      rvld_nxt;
  logic                      wdone_r;     // Write done pulse
  logic                      wdone_nxt;
  logic                      busy_r;      // Request refused while set
  logic                      busy_nxt;

  // ==========================================================
  // Decodes
  // ==========================================================
  // A request counts only while idle; any other time it is dropped
  wire logic take_req  = i_req && (state_r == asrc_pkg::ASRC_IDLE);
  // Counter runs down; zero marks the last cycle of a phase
  wire logic cnt_done  = (cnt_r == '0);
  // Loads are one less than the cycle count, because the cycle
  // in which the counter reads zero is itself part of the phase
  wire logic [asrc_pkg::CNT_W-1:0] rd_load =
    asrc_pkg::CNT_W'(asrc_pkg::RD_CYC - 1);
  wire logic [asrc_pkg::CNT_W-1:0] wr_load =
    asrc_pkg::CNT_W'(asrc_pkg::WR_CYC - 1);
  // Decrement is only used while the count is above zero
  wire logic [asrc_pkg::CNT_W-1:0] cnt_dec = cnt_r - 1'b1;

  // ==========================================================
  // Next-state logic
  // ==========================================================
  // One access at a time; the select is dropped between accesses
  // so every read is select-controlled and its address settles
  // a full cycle before the falling edge.
  always_comb begin
    // Hold everything by default; the done pulses last one cycle
    // Only one access is in flight, so one counter serves both
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    sel_b_nxt = sel_b_r;
    wr_b_nxt  = wr_b_r;
    addr_nxt  = addr_r;
    wdat_nxt  = wdat_r;
    rdat_nxt  = rdat_r;
    rvld_nxt  = 1'b0;
    wdone_nxt = 1'b0;
    busy_nxt  = busy_r;
    unique case (state_r)
      asrc_pkg::ASRC_IDLE: begin
        // Write data follows on reads too; the RAM ignores it there
        if (take_req) begin
          // Address and data go out with both lines still high
          addr_nxt = i_req_addr;
          wdat_nxt = i_req_wdata;
          busy_nxt = 1'b1;
          state_nxt = i_req_wr ? asrc_pkg::ASRC_WSET
                               : asrc_pkg::ASRC_RSET;
        end
      end
      asrc_pkg::ASRC_RSET: begin
        // Select falls after address is stable, strobe stays high
        sel_b_nxt = 1'b0;
        // Strobe is driven high again so a read never stores
        wr_b_nxt  = 1'b1;
        cnt_nxt   = rd_load;
        state_nxt = asrc_pkg::ASRC_RWAIT;
      end
      asrc_pkg::ASRC_RWAIT: begin
        // Wait access time, then sample what the RAM drives
        if (cnt_done) begin
          rdat_nxt  = i_ram_dout;
          rvld_nxt  = 1'b1;
          // Select rises after every read; holding it low and only
          // moving the address is allowed, but would cost a decode
          sel_b_nxt = 1'b1;
          busy_nxt  = 1'b0;
          state_nxt = asrc_pkg::ASRC_IDLE;
        end else begin
          // Still inside the access time
          cnt_nxt = cnt_dec;
        end
      end
      asrc_pkg::ASRC_WSET: begin
        // Address stood a cycle already, so no separate setup phase
        // Both lines fall together to open the write overlap
        sel_b_nxt = 1'b0;
        wr_b_nxt  = 1'b0;
        cnt_nxt   = wr_load;
        state_nxt = asrc_pkg::ASRC_WPUL;
      end
      asrc_pkg::ASRC_WPUL: begin
        if (cnt_done) begin
          // Raise both together: write ends, outputs stay floating
          sel_b_nxt = 1'b1;
          wr_b_nxt  = 1'b1;
          state_nxt = asrc_pkg::ASRC_WEND;
        end else begin
          // Keep the overlap open for the full pulse width
          cnt_nxt = cnt_dec;
        end
      end
      asrc_pkg::ASRC_WEND: begin
        // Address and data held one cycle past the rising edge;
        // without it a new request could move them on that edge
        wdone_nxt = 1'b1;
        busy_nxt  = 1'b0;
        state_nxt = asrc_pkg::ASRC_IDLE;
      end
      default: begin
        // Unused codes fall back to idle with both lines high
        state_nxt = asrc_pkg::ASRC_IDLE;
        sel_b_nxt = asrc_pkg::RST_SEL_B;
        wr_b_nxt  = asrc_pkg::RST_WR_B;
        busy_nxt  = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Registers
  // ==========================================================
  // Control state resets here; data paths reset in the block below
  // Reset is synchronous, so both lines settle high on the first
  // clock edge that sees the reset low
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      state_r <= asrc_pkg::ASRC_IDLE;
      cnt_r   <= '0;
      sel_b_r <= asrc_pkg::RST_SEL_B;
      wr_b_r  <= asrc_pkg::RST_WR_B;
      rvld_r  <= 1'b0;
      wdone_r <= 1'b0;
      busy_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      sel_b_r <= sel_b_nxt;
      wr_b_r  <= wr_b_nxt;
      rvld_r  <= rvld_nxt;
      wdone_r <= wdone_nxt;
      busy_r  <= busy_nxt;
    end
  end

  // Address and data registers reset to zero for defined pins
  // Kept apart so the pin registers need no state decode
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      addr_r <= '0;
      wdat_r <= '0;
      rdat_r <= '0;
    end else begin
      addr_r <= addr_nxt;
      wdat_r <= wdat_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  // ==========================================================
  // Outputs, all straight from flip-flops
  // ==========================================================
  // No gate sits between a flip-flop and a pin, so pin edges are clean
  assign o_busy          = busy_r;
  assign o_rd_valid      = rvld_r;
  assign o_rd_data       = rdat_r;
  assign o_wr_done       = wdone_r;
  assign o_sel_b         = sel_b_r;
  assign o_wr_b          = wr_b_r;
  assign o_word_address  = addr_r;
  assign o_write_data_in = wdat_r;

endmodule

// ---- bench/asrc_ram_model.sv ----
`timescale 1ns/100ps
// ==========================================================
// RAM partner: 64K x 4 words, overlap-timed writes
module asrc_ram_model (
  input  wire logic [15:0] i_word_address,
  input  wire logic [3:0]  i_write_data_in,
  input  wire logic        i_sel_b,
  input  wire logic        i_wr_b,
  output logic [3:0]       o_dout
);
  logic [3:0] mem [0:65535];        // Storage array
  logic [3:0] last;                 // Floating lines show its inverse
  wire wr_on = !i_sel_b && !i_wr_b;
  wire rd_on = !i_sel_b && i_wr_b;
  // Store on whichever rise ends the overlap
  always @(negedge wr_on) mem[i_word_address] = i_write_data_in;
  always @* if (rd_on) last = mem[i_word_address];
  // No pull on these lines, so a float is never the last value
  assign o_dout = rd_on ? mem[i_word_address] : ~last;
endmodule

// ---- bench/asrc_host_assertions.sv ----
`timescale 1ns/100ps
// ==========================================================
// Pin sequencing checks
module asrc_host_assertions (
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  input wire logic        o_rd_valid,
  input wire logic [3:0]  o_rd_data,
  input wire logic        o_wr_done,
  input wire logic        o_sel_b,
  input wire logic        o_wr_b,
  input wire logic [15:0] o_word_address,
  input wire logic [3:0]  o_write_data_in,
  input wire logic [3:0]  i_ram_dout
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  rd_len_a:
    assert property ($fell(o_sel_b) && o_wr_b |-> !o_sel_b[*3] ##1
      (o_sel_b && o_rd_valid)) else $error("read length");
  rd_strobe_a:
    assert property ($fell(o_sel_b) && o_wr_b |-> o_wr_b[*4])
      else $error("strobe low in read");
  rd_data_a:
    assert property (o_rd_valid |-> o_rd_data == $past(i_ram_dout))
      else $error("read data");
  wr_len_a:
    assert property ($fell(o_wr_b) |-> !o_wr_b[*2] ##1 o_wr_b ##1 o_wr_done)
      else $error("write length");
  wr_start_a:
    assert property ($fell(o_wr_b) |-> $fell(o_sel_b)) else $error("start");
  wr_end_a:
    assert property ($rose(o_wr_b) |-> $rose(o_sel_b)) else $error("end");
  sel_strobe_a:
    assert property (o_sel_b |-> o_wr_b) else $error("strobe unselected");
  data_hold_a:
    assert property (!$past(o_wr_b) |-> $stable(o_write_data_in))
      else $error("data moved");
  addr_hold_a:
    assert property (!o_sel_b || $rose(o_sel_b) |-> $stable(o_word_address))
      else $error("address moved");
endmodule

// ---- bench/tb_asrc_host.sv ----
`timescale 1ns/100ps
// ==========================================================
// Bench: host driving the RAM model
module tb_asrc_host;
  logic        i_clk = 1'b0;
  logic        i_rst_b = 1'b0;
  logic        i_req = 1'b0;
  logic        i_req_wr = 1'b0;
  logic [15:0] i_req_addr = 16'h0000;
  logic [3:0]  i_req_wdata = 4'h0;
  logic        o_busy, o_rd_valid, o_wr_done, o_sel_b, o_wr_b;
  logic [3:0]  o_rd_data, o_write_data_in, i_ram_dout, rd_q;
  logic [15:0] o_word_address;
  int          err_count = 0;
  int          n_checks = 0;
  // Edges from take to done pulse: select falls one edge after take,
  // then the phase counts; a write adds one edge of data hold
  localparam int RD_LAT = asrc_pkg::RD_CYC + 1;
  localparam int WR_LAT = asrc_pkg::WR_CYC + 2;
  always #4 i_clk = ~i_clk;
  asrc_host asrc_host_inst (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_req(i_req), .i_req_wr(i_req_wr), .i_req_addr(i_req_addr),
    .i_req_wdata(i_req_wdata), .o_busy(o_busy), .o_rd_valid(o_rd_valid),
    .o_rd_data(o_rd_data), .o_wr_done(o_wr_done), .o_sel_b(o_sel_b),
    .o_wr_b(o_wr_b), .o_word_address(o_word_address),
    .o_write_data_in(o_write_data_in), .i_ram_dout(i_ram_dout));
  asrc_ram_model asrc_ram_model_inst (.i_word_address(o_word_address),
    .i_write_data_in(o_write_data_in), .i_sel_b(o_sel_b),
    .i_wr_b(o_wr_b), .o_dout(i_ram_dout));
  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] seen);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Issue one access now; hold keeps a refused request up meanwhile
  task automatic access(input logic w, input logic [15:0] a,
                        input logic [3:0] d, input int hold);
    int n;
    n = 0;
    i_req = 1'b1;
    i_req_wr = w;
    i_req_addr = a;
    i_req_wdata = d;
    @(posedge i_clk);
    #1;
    check("busy set", 16'h0001, {15'h0000, o_busy});
    i_req_wr = ~w;
    i_req_wdata = ~d;
    // n counts edges after the take edge, refused ones included
    repeat (hold) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    i_req = 1'b0;
    while (o_rd_valid !== 1'b1 && o_wr_done !== 1'b1 && n < 12) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    check("latency", 16'(w ? WR_LAT : RD_LAT), 16'(n));
    check("done", {14'h0, w, ~w}, {14'h0, o_wr_done, o_rd_valid});
    check("busy clear", 16'h0000, {15'h0000, o_busy});
    check("pin addr", a, o_word_address);
    if (w) check("pin data", {12'h000, d}, {12'h000, o_write_data_in});
    rd_q = o_rd_data;
  endtask
  // Extreme addresses, back to back, one overwritten
  task automatic sc_edges();
    access(1'b1, 16'h0000, 4'h5, 0);
    access(1'b1, 16'hffff, 4'h3, 0);
    access(1'b1, 16'hffff, 4'ha, 0);
    access(1'b0, 16'h0000, 4'h0, 0);
    check("rd 0000", 16'h0005, {12'h000, rd_q});
    access(1'b0, 16'hffff, 4'h0, 0);
    check("rd ffff", 16'h000a, {12'h000, rd_q});
  endtask
  // A write asked for while busy must leave no trace
  task automatic sc_refused();
    access(1'b1, 16'h0042, 4'h6, 0);
    access(1'b0, 16'h0042, 4'h0, 3);
    check("busy rd", 16'h0006, {12'h000, rd_q});
    access(1'b0, 16'h0042, 4'h0, 0);
    check("after", 16'h0006, {12'h000, rd_q});
  endtask
  initial begin
    repeat (8) @(posedge i_clk);
    #1;
    i_rst_b = 1'b1;
    check("idle pins", 16'h0003, {14'h0000, o_sel_b, o_wr_b});
    sc_edges();
    sc_refused();
    give_verdict();
  end
  // Whole run is well under a hundred cycles of traffic
  initial begin
    #20000;
    err_count++;
    give_verdict();
  end
endmodule
bind asrc_host asrc_host_assertions asrc_host_assertions_inst (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .o_rd_valid(o_rd_valid),
  .o_rd_data(o_rd_data), .o_wr_done(o_wr_done), .o_sel_b(o_sel_b),
  .o_wr_b(o_wr_b), .o_word_address(o_word_address),
  .o_write_data_in(o_write_data_in), .i_ram_dout(i_ram_dout));
